// ==== swg_adapter_end.sv ====
// Adapter end: drives permits and accept mask, feeds received packets.
// Assumes the switch end on the link interface and the same byte clock.
`timescale 1ns/10ps
`include "swg_consts.svh"

module swg_adapter_end (
   input  wire logic         ref_clk,
   input  wire logic         rst_b,
   swg_link_if.adp           link,
   input  wire logic [15:0]  permitReq,
   input  wire logic [15:0]  acceptReq,
   input  wire logic         pktValid,
   output logic              pktReady,
   input  wire logic [3:0]   pktPort,
   input  wire logic         pktCtrl,
   input  wire logic         pktColour,
   input  wire logic [15:0]  pktBitmap,
   output logic              outStart,
   output logic [3:0]        outPort,
   output swg_pkg::swg_kind_t outKind,
   output logic              outColour,
   output logic [8:0]        outRowA,
   output logic [8:0]        outRowB,
   output logic              outTwoRows,
   output logic              outCrcEn
);
   logic [15:0] permitQ;
   logic [15:0] acceptQ;
   logic        rxValidQ;
   logic        load;

   assign link.output_send_permit = permitQ;
   assign link.queue_accept_mask  = acceptQ;
   assign link.rxValid = rxValidQ;
   assign pktReady = !rxValidQ || link.rxReady;
   assign load     = pktValid && pktReady;

   // A permit bit moves just after its own output slot, so it is stable
   // through the next sampling window and N slots give exactly N packets
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         permitQ <= '0;
      end else if (link.txStart) begin
         permitQ[link.txPort] <= permitReq[link.txPort];
      end
   end

   // Mask changes only at packet boundaries, common to all inputs
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         acceptQ <= '0;
      end else if (load) begin
         acceptQ <= acceptReq;
      end
   end

   // One register stage toward the switch; stalls on its back-pressure
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rxValidQ      <= 1'b0;
         link.rxPort   <= '0;
         link.rxCtrl   <= 1'b0;
         link.rxColour <= 1'b0;
         link.rxBitmap <= '0;
      end else if (pktReady) begin
         rxValidQ      <= pktValid;
         link.rxPort   <= pktPort;
         link.rxCtrl   <= pktCtrl;
         link.rxColour <= pktColour;
         link.rxBitmap <= pktBitmap;
      end
   end

   // Capture each slot descriptor for the line
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         outStart   <= 1'b0;
         outPort    <= '0;
         outKind    <= swg_pkg::SWG_TX_IDLE;
         outColour  <= 1'b0;
         outRowA    <= '0;
         outRowB    <= '0;
         outTwoRows <= 1'b0;
         outCrcEn   <= 1'b0;
      end else begin
         outStart   <= link.txStart;
         outPort    <= link.txPort;
         outKind    <= link.txKind;
         outColour  <= link.txColour;
         outRowA    <= link.txRowA;
         outRowB    <= link.txRowB;
         outTwoRows <= link.txTwoRows;
         outCrcEn   <= link.txCrcEn;
      end
   end
endmodule

// ==== swg_consts.svh ====
// Constants of the switch output grant and queue control block.
// Assumes inclusion by bare name from the switch end and adapter end files.
`ifndef SWG_CONSTS_SVH
`define SWG_CONSTS_SVH

`define SWG_NPORT     16
`define SWG_PORT_W    4
`define SWG_NADDR     32
`define SWG_AIDX_W    5
`define SWG_CNT_W     5
`define SWG_ROW_W     9
`define SWG_OQ_DEPTH  4
`define SWG_CQ_DEPTH  16
`define SWG_POOL_BASE 9'h002
`define SWG_ROW_ZERO  9'h000
`define SWG_ROW_ONE   9'h001
`define SWG_ROW_HIGH  9'h100
`define SWG_SYNC_W    32

`endif

// ==== swg_link_assertions.sv ====
// Checker of the switch grant link: slots, descriptors, receive handshake.
// Assumes one byte clock on both ends; placed beside the link instance.
`timescale 1ns/10ps
// ****************************************
// Link checker
// ****************************************
module swg_link_assertions (
   input wire logic               ref_clk,
   input wire logic               rst_b,
   input wire logic [15:0]        output_send_permit,
   input wire logic               rxValid,
   input wire logic               rxReady,
   input wire logic [3:0]         rxPort,
   input wire logic [15:0]        rxBitmap,
   input wire logic               txStart,
   input wire logic [3:0]         txPort,
   input wire swg_pkg::swg_kind_t txKind,
   input wire logic [8:0]         txRowA,
   input wire logic [8:0]         txRowB,
   input wire logic               txTwoRows,
   input wire logic               txCrcEn
);
   // All checks share the byte clock and its reset
   default clocking dc @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   slot_every_a:
      assert property (1'b1 |=> txStart) else $error("slot missed");
   port_turn_a:
      assert property (txStart && $past(txStart) |-> txPort == $past(txPort) + 4'h1)
         else $error("outputs not served in turn");
   port_period_a:
      assert property (txStart && txPort == 4'h0 |-> ##16 txPort == 4'h0)
         else $error("output zero not back after sixteen slots");
   crc_data_a:
      assert property (txStart |-> txCrcEn == (txKind == swg_pkg::SWG_TX_DATA))
         else $error("checksum flag on a non-data packet");
   // Permit bits change just after their own slot, so eight cycles back is settled
   send_permit_a:
      assert property (txKind != swg_pkg::SWG_TX_IDLE |->
         (($past(output_send_permit, 8) >> txPort) & 16'h0001) == 16'h0001)
         else $error("packet sent while permit low");
   ctrl_row_a:
      assert property (txKind == swg_pkg::SWG_TX_CTRL |-> txRowA == 9'h000 &&
         (!txTwoRows || txRowB == 9'h001 || txRowB == 9'h100))
         else $error("control packet on an unreserved row");
   data_row_a:
      assert property (txKind == swg_pkg::SWG_TX_DATA |-> txRowA >= 9'h002 &&
         txRowA <= 9'h021) else $error("data row outside the pool");
   rx_hold_a:
      assert property (rxValid && !rxReady |=> rxValid && $stable(rxPort) &&
         $stable(rxBitmap)) else $error("offered packet changed before taken");

   cover property (txKind == swg_pkg::SWG_TX_DATA);
   cover property (txKind == swg_pkg::SWG_TX_CTRL && txTwoRows);
   cover property (rxValid && rxReady);
endmodule

// ==== swg_link_if.sv ====
// Link between the switch core and its line adapters.
// Assumes both ends run on the same byte clock; permit and mask are still
// treated by the switch as asynchronous pins.
`timescale 1ns/10ps
interface swg_link_if;
   logic [15:0]       output_send_permit;
   logic [15:0]       queue_accept_mask;
   logic              rxValid;
   logic              rxReady;
   logic [3:0]        rxPort;
   logic              rxCtrl;
   logic              rxColour;
   logic [15:0]       rxBitmap;
   logic              txStart;
   logic [3:0]        txPort;
   swg_pkg::swg_kind_t txKind;
   logic              txColour;
   logic [8:0]        txRowA;
   logic [8:0]        txRowB;
   logic              txTwoRows;
   logic              txCrcEn;

   modport dev (
      input  output_send_permit, queue_accept_mask, rxValid, rxPort, rxCtrl,
      input  rxColour, rxBitmap,
      output rxReady, txStart, txPort, txKind, txColour, txRowA, txRowB,
      output txTwoRows, txCrcEn
   );
   modport adp (
      output output_send_permit, queue_accept_mask, rxValid, rxPort, rxCtrl,
      output rxColour, rxBitmap,
      input  rxReady, txStart, txPort, txKind, txColour, txRowA, txRowB,
      input  txTwoRows, txCrcEn
   );
endinterface

// ==== swg_pkg.sv ====
// Types shared by both ends of the switch output grant link.
// Assumes nothing beyond a SystemVerilog compiler.
package swg_pkg;

   // Kind of packet placed on an output in one slot
   typedef enum logic [1:0] {
      SWG_TX_IDLE = 2'b00,
      SWG_TX_DATA = 2'b01,
      SWG_TX_CTRL = 2'b11
   } swg_kind_t;

   // Configuration of the reserved control packet rows
   typedef struct packed {
      logic       twoRows;
      logic [8:0] rowA;
      logic [8:0] rowB;
   } swg_rows_t;

endpackage

// ==== swg_switch_end.sv ====
// Switch end: output queues, address pool, control queue, slot scheduler.
// Assumes the adapter end on the link interface and a local processor on
// the plain user ports; one 100 MHz byte clock, one output served per cycle.
//
// Notes on behaviour
// - Every output sends something in every slot
// - Normal idle when no data or permit low
// - Colour force sends the configured colour
// - Expected colour only if all seen, queue empty
// - Control packets carry grants, no checksum bits
// - Sixteen send permits gate data and control
// - Async permit gives N-1 to N+1 packets
// - Aligned permit gives exactly N packets
// - Accept mask blocks enqueue per output queue
// - Accept mask ANDed with destination bitmap filter
// - Adapters hold mask stable, start together
// - Software disables colour, filter all ones
// - Disabled port queue slowly flushed, permit ignored
// - Pool hands addresses, counts destinations, frees zero
// - Output queue entries carry parity checked on read
// - Counter misuse or parity sets corruption flag
// - Control addresses go to separate queue
// - Control queue holds sixteen, drops when full
// - Accepted control packet sets received flag
// - Receiving input port stored with control packet
// - Reserved rows depend on expansion and size
// - Reserved rows sent on processor command
`timescale 1ns/10ps
`include "swg_consts.svh"

// ****************************************************************
// Parameterised FIFO
// ****************************************************************
module swg_fifo #(
   parameter int W = 8,
   parameter int D = 4
) (
   input  wire logic         ref_clk,
   input  wire logic         rst_b,
   input  wire logic         inValid,
   output logic              inReady,
   input  wire logic [W-1:0] inData,
   output logic              outValid,
   input  wire logic         outReady,
   output logic [W-1:0]      outData
);
   localparam int AW = $clog2(D);
   logic [W-1:0] memQ [D];
   logic [AW-1:0] wrQ;
   logic [AW-1:0] rdQ;
   logic [AW:0]   cntQ;
   logic          push;
   logic          pop;

   assign inReady  = (cntQ != (AW+1)'(D));
   assign outValid = (cntQ != '0);
   assign outData  = memQ[rdQ];
   assign push     = inValid && inReady;
   assign pop      = outValid && outReady;

   // Storage has no reset; only the pointers and the count need a defined value
   always_ff @(posedge ref_clk) begin
      if (push) begin
         memQ[wrQ] <= inData;
      end
   end

   // Pointers wrap naturally since depth is a power of two
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         wrQ  <= '0;
         rdQ  <= '0;
         cntQ <= '0;
      end else begin
         if (push) wrQ <= wrQ + 1'b1;
         if (pop) rdQ <= rdQ + 1'b1;
         cntQ <= cntQ + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// ****************************************************************
// Switch end
// ****************************************************************
module swg_switch_end (
   input  wire logic        ref_clk,
   input  wire logic        rst_b,
   swg_link_if.dev          link,
   input  wire logic [15:0] portEnable,
   input  wire logic [15:0] bitmapFilter,
   input  wire logic        colourForce,
   input  wire logic        colourCfg,
   input  wire logic        expectedColour,
   input  wire logic        colourClear,
   input  wire logic        extExpansion,
   input  wire logic        intExpansion,
   input  wire logic        bigPacket,
   input  wire logic        ctrlSendReq,
   input  wire logic [15:0] ctrlSendMask,
   output logic             ctrlSendBusy,
   output logic             cqValid,
   input  wire logic        cqPop,
   output logic [8:0]       cqRow,
   output logic [3:0]       cqPort,
   output logic             addrCorrupt,
   input  wire logic        addrCorruptClr,
   input  wire logic        addrCorruptMask,
   output logic             ctrlRcvd,
   input  wire logic        ctrlRcvdClr,
   input  wire logic        ctrlRcvdMask,
   output logic             mainIrq
);
   localparam int NP = `SWG_NPORT;
   localparam int NA = `SWG_NADDR;
   localparam int AI = `SWG_AIDX_W;

   // Lowest free pool entry, bit AI flags that one was found
   function automatic logic [AI:0] firstFree(input logic [NA-1:0] busy);
      logic [AI:0] r;
      r = '0;
      for (int k = NA - 1; k >= 0; k--) begin
         if (!busy[k]) r = {1'b1, AI'(k)};
      end
      return r;
   endfunction

   // Number of destinations in a bitmap
   function automatic logic [4:0] destCount(input logic [15:0] m);
      logic [4:0] c;
      c = '0;
      for (int k = 0; k < 16; k++) c = c + 5'(m[k]);
      return c;
   endfunction

   // Reserved row set for the current expansion mode and packet size
   function automatic swg_pkg::swg_rows_t resRows(input logic ext, input logic intx,
                                                 input logic big);
      swg_pkg::swg_rows_t r;
      r.rowA    = `SWG_ROW_ZERO;
      r.rowB    = intx ? `SWG_ROW_HIGH : `SWG_ROW_ONE;
      r.twoRows = !ext || big;
      return r;
   endfunction

   // ****************************************************************
   // Pin synchroniser
   // ****************************************************************
   logic [31:0] syn1Q, syn2Q, syn3Q, pinQ;
   logic [15:0] permit;
   logic [15:0] accept;

   // Three stages; a bit moves only once stages two and three agree
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         syn1Q <= '0;
         syn2Q <= '0;
         syn3Q <= '0;
         pinQ  <= '0;
      end else begin
         syn1Q <= {link.queue_accept_mask, link.output_send_permit};
         syn2Q <= syn1Q;
         syn3Q <= syn2Q;
         pinQ  <= (syn2Q & ~(syn2Q ^ syn3Q)) | (pinQ & (syn2Q ^ syn3Q));
      end
   end
   assign permit = pinQ[15:0];
   assign accept = pinQ[31:16];

   // ****************************************************************
   // Receive side
   // ****************************************************************
   logic [NA-1:0] busyQ;
   logic [4:0]    occQ [NA];
   logic [AI:0]   freeSel;
   logic [15:0]   mask;
   logic [NP-1:0] oqInReady, oqOutValid, oqOutReady;
   logic [AI:0]   oqOut [NP];
   logic          cqInReady, take, enIn, dataAcc, ctrlAcc, alloc;
   logic [4:0]    allocCnt;
   logic [AI+4-1:0] cqOut;

   assign freeSel = firstFree(busyQ);
   assign mask    = link.rxBitmap & bitmapFilter & accept & portEnable;
   assign enIn    = portEnable[link.rxPort];
   // Back-pressure: data stalls until a pool entry and every target queue have room; control stalls only while the pool is empty and its queue has room
   assign link.rxReady = link.rxCtrl ? (freeSel[AI] || !cqInReady)
                       : ((freeSel[AI] || mask == '0) && &(oqInReady | ~mask));
   assign take     = link.rxValid && link.rxReady;
   assign dataAcc  = take && enIn && !link.rxCtrl && mask != '0;
   assign ctrlAcc  = take && enIn && link.rxCtrl && cqInReady;
   assign alloc    = dataAcc || ctrlAcc;
   assign allocCnt = ctrlAcc ? 5'h01 : destCount(mask);

   // ****************************************************************
   // Queues
   // ****************************************************************
   for (genvar j = 0; j < NP; j++) begin : g_oq
      swg_fifo #(.W(AI + 1), .D(`SWG_OQ_DEPTH)) u_oq (
         .ref_clk  (ref_clk),
         .rst_b    (rst_b),
         .inValid  (dataAcc && mask[j]),
         .inReady  (oqInReady[j]),
         .inData   ({^freeSel[AI-1:0], freeSel[AI-1:0]}),
         .outValid (oqOutValid[j]),
         .outReady (oqOutReady[j]),
         .outData  (oqOut[j])
      );
   end

   // Control queue is separate from the data queues and keeps the input port
   swg_fifo #(.W(AI + 4), .D(`SWG_CQ_DEPTH)) u_cq (
      .ref_clk  (ref_clk),
      .rst_b    (rst_b),
      .inValid  (take && enIn && link.rxCtrl),
      .inReady  (cqInReady),
      .inData   ({link.rxPort, freeSel[AI-1:0]}),
      .outValid (cqValid),
      .outReady (cqPop),
      .outData  (cqOut)
   );
   assign cqPort = cqOut[AI+3:AI];
   assign cqRow  = `SWG_POOL_BASE + {4'h0, cqOut[AI-1:0]};

   // ****************************************************************
   // Slot scheduler
   // ****************************************************************
   logic [3:0]  slotQ;
   logic [15:0] ctrlPendQ;
   logic [15:0] seenQ;
   logic        txPop, sendCtrl, parErr;
   logic [AI:0] head;

   assign head      = oqOut[slotQ];
   assign sendCtrl  = portEnable[slotQ] && permit[slotQ] && ctrlPendQ[slotQ];
   // Disabled ports drain regardless of permit; permit only at slot turn
   assign txPop = oqOutValid[slotQ] && !sendCtrl
               && (!portEnable[slotQ] || permit[slotQ]);
   assign parErr = txPop && ^head;
   for (genvar j = 0; j < NP; j++) begin : g_pop
      assign oqOutReady[j] = txPop && (slotQ == 4'(j));
   end
   assign ctrlSendBusy = |ctrlPendQ;

   // One output per cycle, so every output meets a slot once per transfer unit
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         slotQ <= '0;
      end else begin
         slotQ <= slotQ + 1'b1;
      end
   end

   // Pending control transmissions; a new command wins over the clear
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrlPendQ <= '0;
      end else begin
         ctrlPendQ <= (ctrlPendQ & ~(16'(sendCtrl) << slotQ))
                    | (ctrlSendReq ? ctrlSendMask : 16'h0000);
      end
   end

   // Colour seen per input since the last clear; arrival wins over clear
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         seenQ <= '0;
      end else begin
         seenQ <= (colourClear ? 16'h0000 : seenQ)
                | ((take && link.rxColour == expectedColour) ? (16'h0001 << link.rxPort)
                   : 16'h0000);
      end
   end

   // Slot descriptor; the data outputs all come from flip-flops
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         link.txStart   <= 1'b0;
         link.txPort    <= '0;
         link.txKind    <= swg_pkg::SWG_TX_IDLE;
         link.txColour  <= 1'b0;
         link.txRowA    <= '0;
         link.txRowB    <= '0;
         link.txTwoRows <= 1'b0;
         link.txCrcEn   <= 1'b0;
      end else begin
         link.txStart   <= 1'b1;
         link.txPort    <= slotQ;
         link.txTwoRows <= 1'b0;
         link.txCrcEn   <= 1'b0;
         if (sendCtrl) begin
            link.txKind    <= swg_pkg::SWG_TX_CTRL;
            link.txRowA    <= resRows(extExpansion, intExpansion, bigPacket).rowA;
            link.txRowB    <= resRows(extExpansion, intExpansion, bigPacket).rowB;
            link.txTwoRows <= resRows(extExpansion, intExpansion, bigPacket).twoRows;
         end else if (txPop && portEnable[slotQ]) begin
            link.txKind  <= swg_pkg::SWG_TX_DATA;
            link.txRowA  <= `SWG_POOL_BASE + {4'h0, head[AI-1:0]};
            link.txCrcEn <= 1'b1;
         end else begin
            link.txKind   <= swg_pkg::SWG_TX_IDLE;
            link.txColour <= colourForce ? colourCfg
                           : ((&seenQ && !oqOutValid[slotQ]) ? expectedColour
                              : !expectedColour);
         end
      end
   end

   // ****************************************************************
   // Address pool and occupancy counters
   // ****************************************************************
   logic cqTake;
   logic badInit, badFree;
   assign cqTake  = cqValid && cqPop;
   assign badInit = alloc && occQ[freeSel[AI-1:0]] != 5'h00;
   assign badFree = (txPop && occQ[head[AI-1:0]] == 5'h00)
                 || (cqTake && occQ[cqOut[AI-1:0]] == 5'h00);

   // Each transmission takes one off the count; the entry frees at zero
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         busyQ <= '0;
         for (int k = 0; k < NA; k++) occQ[k] <= '0;
      end else begin
         for (int k = 0; k < NA; k++) begin
            logic [4:0] dec;
            dec = 5'(txPop && head[AI-1:0] == AI'(k))
                + 5'(cqTake && cqOut[AI-1:0] == AI'(k));
            if (alloc && freeSel[AI-1:0] == AI'(k)) begin
               occQ[k]  <= allocCnt;
               busyQ[k] <= 1'b1;
            end else if (dec != 5'h00 && occQ[k] >= dec) begin
               occQ[k] <= occQ[k] - dec;
               if (occQ[k] == dec) busyQ[k] <= 1'b0;
            end
         end
      end
   end

   // ****************************************************************
   // Event flags
   // ****************************************************************
   // Sticky; a new event in the clearing cycle keeps the flag set
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         addrCorrupt <= 1'b0;
         ctrlRcvd    <= 1'b0;
      end else begin
         addrCorrupt <= (addrCorrupt && !addrCorruptClr) || badInit || badFree
                     || parErr;
         ctrlRcvd    <= (ctrlRcvd && !ctrlRcvdClr) || ctrlAcc;
      end
   end
   assign mainIrq = (addrCorrupt && !addrCorruptMask) || (ctrlRcvd && !ctrlRcvdMask);
endmodule

// ==== test_switch_output_grant_queue_control.sv ====
// Bench of the switch grant link, both ends joined back to back.
// Assumes the design files and the link checker are compiled first.
`timescale 1ns/10ps
`define CHK(a, b) begin \
   checks_done++; \
   if ((a) !== (b)) begin \
      err_total++; \
      $display("unexpected t=%0t got %h exp %h", $time, a, b); \
   end \
end
// ****************************************
// Bench top
// ****************************************
module test_switch_output_grant_queue_control;
   typedef struct packed {
      logic       ext, intx, big, frc, cfg, expc, two, colour;
      logic [8:0] rowB;
   } swg_case_t;
   // Mode inputs beside the rows and idle colour they should give
   swg_case_t cases [4] = '{17'h03601, 17'h0a500, 17'h10200, 17'h14c01};
   logic        ref_clk = 1'b0;
   logic        rst_b = 1'b0;
   logic [15:0] portEnable, bitmapFilter, ctrlSendMask, permitReq, acceptReq, pktBitmap;
   logic        colourForce, colourCfg, expectedColour, colourClear, extExpansion;
   logic        intExpansion, bigPacket, ctrlSendReq, cqPop, addrCorruptClr, addrCorruptMask;
   logic        ctrlRcvdClr, ctrlRcvdMask, pktValid, pktCtrl, pktColour, ctrlSendBusy;
   logic        cqValid, addrCorrupt, ctrlRcvd, mainIrq, pktReady, outStart, outColour;
   logic        outTwoRows, outCrcEn, lastColour, lastTwo;
   logic [3:0]  pktPort, cqPort, outPort;
   logic [8:0]  cqRow, outRowA, outRowB, lastRowA, lastRowB;
   swg_pkg::swg_kind_t outKind;
   int          err_total = 0;
   int          checks_done = 0;

   always #5 ref_clk = ~ref_clk;

   swg_link_if link ();
   swg_switch_end swg_switch_end_inst (.ref_clk, .rst_b, .link(link), .portEnable,
      .bitmapFilter, .colourForce, .colourCfg, .expectedColour, .colourClear,
      .extExpansion, .intExpansion, .bigPacket, .ctrlSendReq, .ctrlSendMask,
      .ctrlSendBusy, .cqValid, .cqPop, .cqRow, .cqPort, .addrCorrupt, .addrCorruptClr,
      .addrCorruptMask, .ctrlRcvd, .ctrlRcvdClr, .ctrlRcvdMask, .mainIrq);
   swg_adapter_end swg_adapter_end_inst (.ref_clk, .rst_b, .link(link), .permitReq,
      .acceptReq, .pktValid, .pktReady, .pktPort, .pktCtrl, .pktColour, .pktBitmap,
      .outStart, .outPort, .outKind, .outColour, .outRowA, .outRowB, .outTwoRows,
      .outCrcEn);
   swg_link_assertions swg_link_assertions_inst (.ref_clk, .rst_b,
      .output_send_permit(link.output_send_permit), .rxValid(link.rxValid),
      .rxReady(link.rxReady), .rxPort(link.rxPort), .rxBitmap(link.rxBitmap),
      .txStart(link.txStart), .txPort(link.txPort), .txKind(link.txKind),
      .txRowA(link.txRowA), .txRowB(link.txRowB), .txTwoRows(link.txTwoRows),
      .txCrcEn(link.txCrcEn));

   task automatic tick(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      tick(1);
      s = 1'b0;
      tick(1);
   endtask
   // Offer one packet; a spare cycle after release keeps valid from toggling twice
   task automatic send(input logic ctrl, input logic [3:0] port, input logic [15:0] bmap);
      int k;
      {pktValid, pktCtrl, pktPort, pktBitmap} = {1'b1, ctrl, port, bmap};
      #1;
      k = 0;
      while (pktReady !== 1'b1 && k < 50) begin
         tick(1);
         k++;
      end
      err_total += (k == 50);
      tick(1);
      pktValid = 1'b0;
      tick(1);
   endtask
   // Count descriptors of one kind on the given outputs, keep the last one seen
   task automatic watch(input swg_pkg::swg_kind_t kind, input logic [15:0] ports,
                        input int n, output int hits);
      hits = 0;
      repeat (n) begin
         tick(1);
         if (outStart === 1'b1 && outKind === kind && ports[outPort] === 1'b1) begin
            hits++;
            {lastColour, lastTwo, lastRowA, lastRowB} = {outColour, outTwoRows, outRowA, outRowB};
         end
      end
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Run takes some 650 cycles; the watchdog allows 6000, about nine times that
   initial begin
      #60us;
      err_total++;
      final_report();
   end

   initial begin
      int n;
      {portEnable, bitmapFilter, permitReq, acceptReq} = {4{16'hffff}};
      {ctrlSendMask, pktBitmap, pktPort} = {16'h0004, 16'h0000, 4'h0};
      {colourForce, colourCfg, expectedColour, colourClear, extExpansion} = 5'h00;
      {intExpansion, bigPacket, ctrlSendReq, cqPop, addrCorruptClr} = 5'h00;
      {addrCorruptMask, ctrlRcvdClr, ctrlRcvdMask, pktValid, pktCtrl, pktColour} = 6'h00;
      tick(10);
      `CHK(outStart, 1'b0)
      rst_b = 1'b1;
      send(1'b0, 4'h0, 16'h0000);
      tick(40);
      // Reserved rows per mode, sent on command, then the idle colour
      foreach (cases[i]) begin
         {extExpansion, intExpansion, bigPacket} = {cases[i].ext, cases[i].intx, cases[i].big};
         {colourForce, colourCfg, expectedColour} = {cases[i].frc, cases[i].cfg, cases[i].expc};
         pulse(colourClear);
         pulse(ctrlSendReq);
         watch(swg_pkg::SWG_TX_CTRL, 16'h0004, 40, n);
         `CHK(n, 1)
         `CHK(lastRowA, 9'h000)
         `CHK(lastTwo, cases[i].two)
         if (cases[i].two) `CHK(lastRowB, cases[i].rowB)
         `CHK(ctrlSendBusy, 1'b0)
         watch(swg_pkg::SWG_TX_IDLE, 16'hffff, 4, n);
         `CHK(lastColour, cases[i].colour)
      end
      // Multicast to two outputs goes out once on each
      send(1'b0, 4'h0, 16'h0028);
      watch(swg_pkg::SWG_TX_DATA, 16'h0028, 40, n);
      `CHK(n, 2)
      // Accept mask and bitmap filter each block one queue
      {acceptReq, bitmapFilter} = {16'hfff7, 16'hffef};
      send(1'b0, 4'h0, 16'h0000);
      tick(8);
      send(1'b0, 4'h0, 16'h0018);
      watch(swg_pkg::SWG_TX_DATA, 16'h0018, 40, n);
      `CHK(n, 0)
      {acceptReq, bitmapFilter} = {16'hffff, 16'hffff};
      send(1'b0, 4'h0, 16'h0000);
      // Permit low holds the packet back until raised
      permitReq = 16'hfff7;
      tick(40);
      send(1'b0, 4'h1, 16'h0008);
      watch(swg_pkg::SWG_TX_DATA, 16'h0008, 40, n);
      `CHK(n, 0)
      permitReq = 16'hffff;
      watch(swg_pkg::SWG_TX_DATA, 16'h0008, 40, n);
      `CHK(n, 1)
      // A disabled port drains its queue with its permit low
      permitReq = 16'hfff7;
      tick(40);
      send(1'b0, 4'h1, 16'h0008);
      portEnable = 16'hfff7;
      tick(40);
      {portEnable, permitReq} = {16'hffff, 16'hffff};
      watch(swg_pkg::SWG_TX_DATA, 16'h0008, 40, n);
      `CHK(n, 0)
      // Seventeen control packets: sixteen kept in order, the last dropped
      for (int i = 0; i < 17; i++) send(1'b1, i[3:0], 16'h0000);
      tick(2);
      `CHK(ctrlRcvd, 1'b1)
      `CHK(mainIrq, 1'b1)
      ctrlRcvdMask = 1'b1;
      tick(1);
      `CHK(mainIrq, 1'b0)
      pulse(ctrlRcvdClr);
      `CHK(ctrlRcvd, 1'b0)
      n = 0;
      while (cqValid === 1'b1 && n < 20) begin
         `CHK({cqPort, cqRow}, {n[3:0], 9'(n + 2)})
         pulse(cqPop);
         n++;
      end
      `CHK(n, 16)
      `CHK(addrCorrupt, 1'b0)
      // Second reset in mid-run
      rst_b = 1'b0;
      tick(2);
      `CHK(cqValid, 1'b0)
      rst_b = 1'b1;
      tick(3);
      `CHK(outStart, 1'b1)
      final_report();
   end
endmodule
